// [efc_pkg.sv]
// package: register map, field positions and reset values of the feature control bank
package efc_pkg;
    localparam int unsigned ADDR_W        = 12;
    localparam int unsigned IDX_W         = 8;
    localparam int unsigned IDX_LSB       = 2;
    localparam logic [IDX_W-1:0] IDX_PAGE_SEL    = 8'h02;
    localparam logic [IDX_W-1:0] IDX_EN_A        = 8'h04;
    localparam logic [IDX_W-1:0] IDX_EN_B        = 8'h05;
    localparam logic [IDX_W-1:0] IDX_PAGE_ADDR   = 8'h08;
    localparam logic [IDX_W-1:0] IDX_PAGE_VALUE  = 8'h09;
    localparam logic [IDX_W-1:0] IDX_ROUTE1      = 8'h0a;
    localparam logic [IDX_W-1:0] IDX_PAGE_MODE   = 8'h17;
    localparam logic [IDX_W-1:0] IDX_SYS_CTRL    = 8'h20;
    localparam logic [IDX_W-1:0] IDX_IRQ_STATUS  = 8'h21;
    localparam logic [IDX_W-1:0] IDX_IRQ_MASK    = 8'h22;

    localparam logic [7:0] PAGE_SEL_RST    = 8'h01;
    localparam int unsigned PAGE_SEL_LSB   = 4;
    localparam int unsigned PAGE_SEL_W     = 4;
    localparam int unsigned PAGE_FIX_BIT   = 0;
    localparam int unsigned SIGMOTION_BIT  = 5;
    localparam int unsigned TILT_BIT       = 4;
    localparam int unsigned STEP_ALGO_BIT  = 3;
    localparam int unsigned STEP_ADV_BIT   = 4;
    localparam int unsigned COMPRESS_BIT   = 3;
    localparam int unsigned SM_EN_BIT      = 0;
    localparam int unsigned R_LONG_BIT     = 7;
    localparam int unsigned R_SIG_BIT      = 5;
    localparam int unsigned R_TILT_BIT     = 4;
    localparam int unsigned R_STEP_BIT     = 3;
    localparam logic [7:0] ROUTE_MASK      = 8'hb8;
    localparam int unsigned PAGE_WRITE_BIT = 6;
    localparam int unsigned PAGE_READ_BIT  = 5;
    localparam int unsigned MASTER_RT_BIT  = 0;
    localparam int unsigned RT_COMPR_BIT   = 1;
    localparam int unsigned BANK_EN_BIT    = 2;
    localparam logic [7:0] BYTE_ZERO       = 8'h00;
    localparam logic [7:0] EN_A_MASK       = 8'h38;
    localparam logic [7:0] EN_B_MASK       = 8'h19;
    localparam logic [7:0] PAGE_MODE_MASK  = 8'h60;
    localparam logic [7:0] SYS_CTRL_MASK   = 8'h07;
endpackage

// [efc_mem_if.sv]
// interface: page memory port between the register bank and the page store
`timescale 1ns/1ps
interface efc_mem_if #(parameter int AW = 12);
    logic          we;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem  (input we, input addr, input wdata, output rdata);
endinterface

// [efc_page_mem.sv]
// module: byte store holding every advanced-feature page, registered read
`timescale 1ns/1ps
module efc_page_mem #(
    parameter int AW = 12
) (
    // clock
    input  wire logic   hclk,
    // port
    efc_mem_if.mem      mp
);
    logic [7:0] store [0:(1<<AW)-1];
    logic [7:0] rdata_r;

    // no reset on the array: page contents are loaded by software
    always_ff @(posedge hclk) begin
        if (mp.we) begin
            store[mp.addr] <= mp.wdata;
        end
        rdata_r <= store[mp.addr];
    end
    assign mp.rdata = rdata_r;
endmodule

// [efc_event_irq.sv]
// module: sticky event status, mask and interrupt output
`timescale 1ns/1ps
module efc_event_irq (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // events and software side
    input  wire logic [7:0] event_vec,
    input  wire logic       status_clear,
    input  wire logic [7:0] mask,
    // results
    output logic [7:0]      status,
    output logic            irq
);
    import efc_pkg::*;
    typedef struct packed {
        logic [7:0] status;
        logic       irq;
    } efc_irq_state_type;
    efc_irq_state_type st_r;
    efc_irq_state_type st_nxt;

    always_comb begin
        st_nxt = st_r;
        // a new event in the clearing cycle survives the clear
        st_nxt.status = ((status_clear ? BYTE_ZERO : st_r.status) | event_vec) & ROUTE_MASK;
        st_nxt.irq = |(st_nxt.status & mask);
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign status = st_r.status;
    assign irq    = st_r.irq;
endmodule

// [efc_regs.sv]
// module: feature control register bank with AHB-Lite slave and pin one routing
`timescale 1ns/1ps
module efc_regs (
    // clock and reset
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    // ahb-lite slave
    input  wire logic                      hsel,
    input  wire logic [31:0]               haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic [31:0]                    hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    // embedded function events, same clock
    input  wire logic                      long_timeout_event,
    input  wire logic                      sigmotion_event,
    input  wire logic                      tilt_event,
    input  wire logic                      step_event,
    // function controls
    output logic                           sigmotion_run,
    output logic                           tilt_run,
    output logic                           step_algo_enable,
    output logic                           step_advanced_enable,
    output logic                           queue_compress_active,
    output logic                           state_machine_enable,
    output logic [efc_pkg::PAGE_SEL_W-1:0] page_select_out,
    // interrupt pins
    output logic                           irq_pin_one,
    output logic                           irq
);
    import efc_pkg::*;

    typedef struct packed {
        logic                   busy;
        logic                   done;
        logic                   wr;
        logic [IDX_W-1:0]       idx;
        logic [PAGE_SEL_W-1:0]  page_sel;
        logic                   page_fix;
        logic [7:0]             en_a;
        logic [7:0]             en_b;
        logic [7:0]             page_addr;
        logic [7:0]             page_value;
        logic [7:0]             route;
        logic [7:0]             page_mode;
        logic [7:0]             sys_ctrl;
        logic [7:0]             irq_mask;
        logic [31:0]            rdata;
        logic                   pin_one;
    } efc_state_type;

    efc_state_type st_r;
    efc_state_type st_nxt;

    efc_mem_if #(.AW(ADDR_W)) mem_bus ();

    logic [7:0] event_vec;
    logic [7:0] status;
    logic       status_clear;
    logic       bank_open;
    logic [7:0] wbyte;

    function automatic logic is_bank_reg(input logic [IDX_W-1:0] i);
        return (i == IDX_PAGE_SEL) || (i == IDX_EN_A) || (i == IDX_EN_B) ||
               (i == IDX_PAGE_ADDR) || (i == IDX_PAGE_VALUE) || (i == IDX_ROUTE1) ||
               (i == IDX_PAGE_MODE);
    endfunction

    // events sit at their routing positions so route, status and mask share one layout
    always_comb begin
        event_vec             = BYTE_ZERO;
        event_vec[R_LONG_BIT] = long_timeout_event;
        event_vec[R_SIG_BIT]  = sigmotion_event;
        event_vec[R_TILT_BIT] = tilt_event;
        event_vec[R_STEP_BIT] = step_event;
    end
    assign bank_open = st_r.sys_ctrl[BANK_EN_BIT];
    assign wbyte     = hwdata[7:0];
    // status is cleared by the read that returns it
    assign status_clear = st_r.done && !st_r.wr && (st_r.idx == IDX_IRQ_STATUS);

    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        // one wait state: the page store needs a cycle to present its byte
        if (st_r.busy) begin
            st_nxt.busy = 1'b0;
            st_nxt.done = 1'b1;
            st_nxt.rdata = '0;
            if (!st_r.wr && (bank_open || !is_bank_reg(st_r.idx))) begin
                unique case (st_r.idx)
                    IDX_PAGE_SEL:   st_nxt.rdata[7:0] = {st_r.page_sel, 3'b000, st_r.page_fix};
                    IDX_EN_A:       st_nxt.rdata[7:0] = st_r.en_a;
                    IDX_EN_B:       st_nxt.rdata[7:0] = st_r.en_b;
                    IDX_PAGE_ADDR:  st_nxt.rdata[7:0] = st_r.page_addr;
                    IDX_PAGE_VALUE: st_nxt.rdata[7:0] = st_r.page_mode[PAGE_READ_BIT] ?
                                                        mem_bus.rdata : st_r.page_value;
                    IDX_ROUTE1:     st_nxt.rdata[7:0] = st_r.route;
                    IDX_PAGE_MODE:  st_nxt.rdata[7:0] = st_r.page_mode;
                    IDX_SYS_CTRL:   st_nxt.rdata[7:0] = st_r.sys_ctrl;
                    IDX_IRQ_STATUS: st_nxt.rdata[7:0] = status;
                    IDX_IRQ_MASK:   st_nxt.rdata[7:0] = st_r.irq_mask;
                    default:        st_nxt.rdata = '0;
                endcase
            end
        end
        // writes land at the end of the data phase, hwdata valid
        if (st_r.done && st_r.wr && (bank_open || !is_bank_reg(st_r.idx))) begin
            unique case (st_r.idx)
                IDX_PAGE_SEL: begin
                    st_nxt.page_sel = wbyte[PAGE_SEL_LSB +: PAGE_SEL_W];
                    st_nxt.page_fix = wbyte[PAGE_FIX_BIT];
                end
                // reserved positions are dropped, software keeps them zero
                IDX_EN_A:       st_nxt.en_a = wbyte & EN_A_MASK;
                IDX_EN_B:       st_nxt.en_b = wbyte & EN_B_MASK;
                IDX_PAGE_ADDR:  st_nxt.page_addr = wbyte;
                IDX_PAGE_VALUE: st_nxt.page_value = wbyte;
                IDX_ROUTE1:     st_nxt.route = wbyte & ROUTE_MASK;
                IDX_PAGE_MODE:  st_nxt.page_mode = wbyte & PAGE_MODE_MASK;
                IDX_SYS_CTRL:   st_nxt.sys_ctrl = wbyte & SYS_CTRL_MASK;
                IDX_IRQ_MASK:   st_nxt.irq_mask = wbyte & ROUTE_MASK;
                default:        st_nxt.page_mode = st_r.page_mode;
            endcase
        end
        if (hsel && hready && htrans[1]) begin
            st_nxt.busy = 1'b1;
            st_nxt.wr   = hwrite;
            st_nxt.idx  = haddr[IDX_LSB +: IDX_W];
        end
        st_nxt.pin_one = st_r.sys_ctrl[MASTER_RT_BIT] &&
                         |(st_r.route & event_vec);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r <= '0;
            st_r.page_fix <= PAGE_SEL_RST[PAGE_FIX_BIT];
        end else begin
            st_r <= st_nxt;
        end
    end

    // page store addressed by selector and address, next values so reads see them at once
    assign mem_bus.addr  = {st_nxt.page_sel, st_nxt.page_addr};
    assign mem_bus.we    = st_r.done && st_r.wr && bank_open &&
                           (st_r.idx == IDX_PAGE_VALUE) &&
                           st_r.page_mode[PAGE_WRITE_BIT];
    assign mem_bus.wdata = wbyte;

    efc_page_mem #(.AW(ADDR_W)) u_mem (
        .hclk (hclk),
        .mp   (mem_bus.mem)
    );

    efc_event_irq u_irq (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .event_vec    (event_vec),
        .status_clear (status_clear),
        .mask         (st_r.irq_mask),
        .status       (status),
        .irq          (irq)
    );

    assign hrdata    = st_r.rdata;
    assign hreadyout = !st_r.busy;
    assign hresp     = 1'b0;

    assign sigmotion_run         = st_r.en_a[SIGMOTION_BIT];
    assign tilt_run              = st_r.en_a[TILT_BIT];
    assign step_algo_enable      = st_r.en_a[STEP_ALGO_BIT];
    assign step_advanced_enable  = st_r.en_b[STEP_ADV_BIT];
    assign queue_compress_active = st_r.en_b[COMPRESS_BIT] &&
                                   st_r.sys_ctrl[RT_COMPR_BIT];
    assign state_machine_enable  = st_r.en_b[SM_EN_BIT];
    assign page_select_out       = st_r.page_sel;
    assign irq_pin_one           = st_r.pin_one;
endmodule

// [efc_regs_chk.sv]
// checker: bus timing, pin routing and control output relations
`timescale 1ns/1ps
module efc_regs_chk (
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // events
    input wire logic        long_timeout_event,
    input wire logic        sigmotion_event,
    input wire logic        tilt_event,
    input wire logic        step_event,
    // outputs
    input wire logic        queue_compress_active,
    input wire logic        state_machine_enable,
    input wire logic [3:0]  page_select_out,
    input wire logic        irq_pin_one,
    input wire logic        irq
);
    logic taken, ev_any, wr_done, wr_ph_r;
    assign taken = hsel && hready && htrans[1];
    assign ev_any = long_timeout_event || sigmotion_event || tilt_event || step_event;
    assign wr_done = wr_ph_r && hreadyout;
    // controls may only move at the edge that completes a write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            wr_ph_r <= 1'b0;
        else if (taken)
            wr_ph_r <= hwrite;
        else if (hreadyout)
            wr_ph_r <= 1'b0;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_wait; !hreadyout ##1 hreadyout; endsequence
    property p_wait; taken |=> s_wait; endproperty
    property p_resp; hresp == 1'b0; endproperty
    property p_rdhi; hrdata[31:8] == 24'h0; endproperty
    property p_quiet; !ev_any |=> !irq_pin_one; endproperty
    property p_sel; $changed(page_select_out) |-> $past(wr_done); endproperty
    property p_cmp; $changed(queue_compress_active) |-> $past(wr_done); endproperty
    property p_sm; $changed(state_machine_enable) |-> $past(wr_done); endproperty
    // a mask write lands one edge after wr_done and raises irq one edge later still
    property p_irq; $rose(irq) |-> $past(ev_any) || $past(wr_done, 2); endproperty
    a_wait: assert property (p_wait) else $error("wait state wrong");
    a_resp: assert property (p_resp) else $error("response not okay");
    a_rdhi: assert property (p_rdhi) else $error("upper read bits set");
    a_quiet: assert property (p_quiet) else $error("pin high without event");
    a_sel: assert property (p_sel) else $error("page select moved");
    a_cmp: assert property (p_cmp) else $error("compress moved");
    a_sm: assert property (p_sm) else $error("state machine moved");
    a_irq: assert property (p_irq) else $error("irq without cause");
endmodule

// [efc_regs_bench.sv]
// testbench: registers, page store, pin routing and interrupt
`timescale 1ns/1ps
module efc_regs_bench;
    import efc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd, seed;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  ev, psel_o;
    logic        sig_o, tilt_o, step_o, adv_o, cmp_o, sm_o, pin_o, irq_o;
    logic [7:0]  ix [5];
    logic [7:0]  sh [5];
    logic [7:0]  pv [4];
    logic [7:0]  pa [4];
    logic [7:0]  ps [4];
    int          miscompares, checks;
    assign hready = hreadyout;
    efc_regs efc_regs_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .long_timeout_event(ev[3]),
        .sigmotion_event(ev[2]), .tilt_event(ev[1]), .step_event(ev[0]), .sigmotion_run(sig_o),
        .tilt_run(tilt_o), .step_algo_enable(step_o), .step_advanced_enable(adv_o),
        .queue_compress_active(cmp_o), .state_machine_enable(sm_o),
        .page_select_out(psel_o), .irq_pin_one(pin_o), .irq(irq_o));
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [7:0] rmap(input logic [3:0] e);
        return {e[3], 1'b0, e[2], e[1], e[0], 3'b000};
    endfunction
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // bounded wait: a hung slave ends the run instead of stalling it
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 40);
        if (hready !== 1'b1) begin
            $display("CHECK FAILED %0t bus wait timed out", $time);
            miscompares++;
            report_and_stop;
        end
    endtask
    task automatic xf(input logic wr, input logic [7:0] i, input logic [7:0] wd);
        @(posedge hclk);
        haddr <= {22'h0, i, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        wait_rdy;
        rd = hrdata;
    endtask
    task automatic rdc(input logic [7:0] i, input logic [7:0] exp);
        xf(1'b0, i, 8'h00);
        cmp(rd, {24'h0, exp});
    endtask
    task automatic pulse(input logic [3:0] e);
        @(posedge hclk);
        ev <= e;
        @(posedge hclk);
        ev <= 4'h0;
        @(posedge hclk);
    endtask
    initial begin
        {hresetn, hwrite, haddr, hwdata, htrans, ev} = '0;
        hsel = 1'b1;
        hsize = 3'b010;
        seed = 32'hafbfcec9;
        ix = '{IDX_PAGE_SEL, IDX_EN_A, IDX_EN_B, IDX_PAGE_ADDR, IDX_ROUTE1};
        sh = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
        miscompares = 0;
        checks = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        // corner case: bank still closed, this write must be dropped
        xf(1'b1, IDX_EN_A, 8'h38);
        xf(1'b1, IDX_SYS_CTRL, 8'h04);
        for (int k = 0; k < 5; k++) rdc(ix[k], sh[k]);
        rdc(IDX_PAGE_VALUE, 8'h00);
        rdc(8'h3f, 8'h00);
        xf(1'b1, IDX_EN_B, 8'hff);
        rdc(IDX_EN_B, 8'h19);
        sh[2] = 8'h19;
        for (int n = 0; n < 30; n++) begin
            seed = xs(seed);
            sh[seed[2:0] % 5] = seed[15:8] & (seed[2:0] % 5 == 0 ? 8'hf1 :
                seed[2:0] % 5 == 1 ? 8'h38 : seed[2:0] % 5 == 2 ? 8'h19 :
                seed[2:0] % 5 == 3 ? 8'hff : 8'hb8) | (seed[2:0] % 5 == 0);
            xf(1'b1, ix[seed[2:0] % 5], sh[seed[2:0] % 5]);
            rdc(ix[seed[2:0] % 5], sh[seed[2:0] % 5]);
            cmp({sig_o, tilt_o, step_o, adv_o, sm_o, psel_o}, {sh[1][5:3], sh[2][4], sh[2][0],
                sh[0][7:4]});
        end
        for (int c = 0; c < 4; c++) begin
            xf(1'b1, IDX_EN_B, {4'h0, c[0], 3'b000});
            xf(1'b1, IDX_SYS_CTRL, {5'h0, 1'b1, c[1], 1'b0});
            @(posedge hclk);
            cmp(cmp_o, c[0] & c[1]);
        end
        for (int p = 0; p < 8; p++) begin
            seed = xs(seed);
            if (p < 4) {ps[p], pa[p], pv[p]} = {seed[7:4], 4'h1, seed[15:10], p[1:0], seed[23:16]};
            xf(1'b1, IDX_PAGE_MODE, p < 4 ? 8'h40 : 8'h20);
            xf(1'b1, IDX_PAGE_SEL, ps[p % 4]);
            xf(1'b1, IDX_PAGE_ADDR, pa[p % 4]);
            if (p < 4) xf(1'b1, IDX_PAGE_VALUE, pv[p]);
            else rdc(IDX_PAGE_VALUE, pv[p % 4]);
        end
        for (int r = 0; r < 20; r++) begin
            seed = xs(seed);
            xf(1'b1, IDX_SYS_CTRL, {5'h0, 2'b10, seed[8] | r[0]});
            xf(1'b1, IDX_ROUTE1, rmap(seed[7:4]));
            @(posedge hclk);
            ev <= seed[3:0];
            repeat (2) @(posedge hclk);
            cmp(pin_o, (seed[8] | r[0]) & |(seed[7:4] & seed[3:0]));
            ev <= 4'h0;
            cmp(irq_o, 1'b0);
        end
        xf(1'b0, IDX_IRQ_STATUS, 8'h00);
        xf(1'b1, IDX_IRQ_MASK, 8'h20);
        pulse(4'b0001);
        cmp(irq_o, 1'b0);
        pulse(4'b0100);
        cmp(irq_o, 1'b1);
        rdc(IDX_IRQ_STATUS, 8'h28);
        rdc(IDX_IRQ_STATUS, 8'h00);
        cmp(irq_o, 1'b0);
        report_and_stop;
    end
endmodule
bind efc_regs efc_regs_chk efc_regs_chk_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hresp(hresp),
    .hreadyout(hreadyout), .long_timeout_event(long_timeout_event), .tilt_event(tilt_event),
    .sigmotion_event(sigmotion_event), .step_event(step_event), .irq(irq),
    .queue_compress_active(queue_compress_active), .irq_pin_one(irq_pin_one),
    .state_machine_enable(state_machine_enable), .page_select_out(page_select_out));
